// ==== sspl_pkg.sv ====
/*
 * Constants shared by the serial program load block of the synthesizer: word
 * width, control codes, field positions inside the three latches, monitor codes
 * and reset values.
 * Assumes nothing of its surroundings; it holds definitions only.
 */
`default_nettype none

package sspl_pkg;

	// Serial word.
	localparam int         SHIFT_W   = 21;
	localparam int         CTRL_W    = 2;
	localparam int         N_LATCH   = 3;
	localparam logic [1:0] CTRL_REF  = 2'h0;
	localparam logic [1:0] CTRL_DIV  = 2'h1;
	localparam logic [1:0] CTRL_FUNC = 2'h2;

	// Latch index of each word kind.
	localparam int LATCH_REF  = 0;
	localparam int LATCH_DIV  = 1;
	localparam int LATCH_FUNC = 2;

	// Reference latch field.
	localparam int REF_LSB = 2;
	localparam int REF_W   = 14;

	// Divider latch fields: swallow count and main count.
	localparam int A_LSB = 2;
	localparam int A_W   = 5;
	localparam int B_LSB = 7;
	localparam int B_W   = 13;

	// Function latch fields.
	localparam int FUNC_PD_BIT       = 3;
	localparam int FUNC_MON_LSB      = 4;
	localparam int FUNC_MON_W        = 3;
	localparam int FUNC_FAST_BIT     = 7;
	localparam int FUNC_PUMP_OFF_BIT = 8;

	// Monitor output selection codes.
	localparam logic [2:0] MON_LOW  = 3'h0;
	localparam logic [2:0] MON_LOCK = 3'h1;
	localparam logic [2:0] MON_NDIV = 3'h2;
	localparam logic [2:0] MON_RDIV = 3'h3;

	// Prescaler.
	localparam int PRESCALE_DEF = 32;
	localparam int PRE_W        = 6;

	// Reset value and pin count.
	localparam logic [SHIFT_W-1:0] LATCH_RST = 21'h000000;
	localparam int                 PIN_N     = 6;

endpackage

`default_nettype wire

// ==== sspl_if.sv ====
/*
 * Carrier between the load logic and the divider chain: programmed counts,
 * sampled input ticks and the divider output pulses.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface sspl_if;
	logic                             run;
	logic                             rf_tick;
	logic                             ref_tick;
	logic [sspl_pkg::REF_W-1:0]       ref_count;
	logic [sspl_pkg::A_W-1:0]         a_count;
	logic [sspl_pkg::B_W-1:0]         b_count;
	logic                             ref_pulse;
	logic                             rf_pulse;

	modport ctrl (
		output run, rf_tick, ref_tick, ref_count, a_count, b_count,
		input  ref_pulse, rf_pulse
	);
	modport div (
		input  run, rf_tick, ref_tick, ref_count, a_count, b_count,
		output ref_pulse, rf_pulse
	);
endinterface

`default_nettype wire

// ==== sspl_div.sv ====
/*
 * Reference divider and dual modulus RF divider with swallow counter.
 * Assumes ticks are one-cycle pulses on the system clock and that the
 * programmed main count is not below the swallow count.
 */
`timescale 1ns/1ps
`default_nettype none

module sspl_div #(
	parameter int PRESCALE = sspl_pkg::PRESCALE_DEF
) (
	// Clock and control.
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic ce_i,
	// Counts in, pulses out.
	sspl_if.div       bus
);
	localparam logic [sspl_pkg::PRE_W-1:0] MOD_P = sspl_pkg::PRE_W'(PRESCALE);

	logic [sspl_pkg::REF_W-1:0] ref_q;
	logic [sspl_pkg::PRE_W-1:0] pre_q;
	logic [sspl_pkg::A_W-1:0]   a_q;
	logic [sspl_pkg::B_W-1:0]   b_q;
	logic                       ref_pulse_q;
	logic                       rf_pulse_q;

	wire                        swallow = (a_q != '0);
	// The prescaler divides by P+1 while the swallow count runs, then by P.
	wire [sspl_pkg::PRE_W-1:0]  mod_top = swallow ? MOD_P : MOD_P - 6'h01; // see R8
	wire                        pre_end = bus.rf_tick && (pre_q == mod_top);
	wire                        b_end   = pre_end && (b_q <= 13'h0001);
	wire                        ref_end = bus.ref_tick && (ref_q <= 14'h0001);

	assign bus.ref_pulse = ref_pulse_q;
	assign bus.rf_pulse  = rf_pulse_q;

	always_ff @(posedge clk_i) begin
		if (rst_i || (ce_i && !bus.run)) begin
			ref_q       <= '0;
			pre_q       <= '0;
			a_q         <= '0;
			b_q         <= '0;
			ref_pulse_q <= 1'b0;
			rf_pulse_q  <= 1'b0;
		end else if (ce_i) begin
			ref_pulse_q <= ref_end;
			rf_pulse_q  <= b_end;
			if (ref_end) begin
				ref_q <= bus.ref_count;
			end else if (bus.ref_tick) begin
				ref_q <= ref_q - 14'h0001;
			end
			if (bus.rf_tick) begin
				pre_q <= pre_end ? '0 : pre_q + 6'h01; // see R8
			end
			if (b_end) begin
				a_q <= bus.a_count;
				b_q <= bus.b_count;
			end else if (pre_end) begin
				b_q <= b_q - 13'h0001;
				if (swallow) begin
					a_q <= a_q - 5'h01;
				end
			end
		end
	end

	AST_PRESCALE_BOUND: assert property (@(posedge clk_i) disable iff (rst_i) // see R8
		pre_q <= MOD_P)
		else $error("Prescaler count passed its modulus.");

	AST_PRESCALE_WRAP: assert property (@(posedge clk_i) disable iff (rst_i) // see R8
		(ce_i && bus.run && pre_end && !swallow) |=> (pre_q == '0))
		else $error("Prescaler did not wrap at its modulus.");

endmodule // sspl_div

`default_nettype wire

// ==== sspl_top.sv ====
/*
 * Serial programming front end of a frequency synthesizer: shift register,
 * three load latches, power control, phase detector and monitor output.
 * Assumes every pin input comes from outside the system clock domain and that
 * the serial clock is much slower than the system clock.
 */
// Function
// R1: Sample data on serial clock rise, shift 21 bits.
// R2: Host sends each word most significant bit first.
// R3: Last two bits shifted select the target latch.
// R4: Load strobe rise copies word into selected latch.
// R5: Enable low powers down, pump output high impedance.
// R6: Enable high powers up unless power-down bit set.
// R7: Monitor shows divider outputs or lock detect.
// R8: Prescaler divides by P or P+1.
// R9: Host holds strobe low until word complete.
// R10: Shifting never disturbs latches; only strobe loads them.
`timescale 1ns/1ps
`default_nettype none

module sspl_top #(
	parameter int PRESCALE = sspl_pkg::PRESCALE_DEF
) (
	// Clock, reset and enable.
	input  wire logic                         CLK_SYS_I,
	input  wire logic                         RST_I,
	input  wire logic                         CE_I,
	// Serial programming pins.
	input  wire logic                         SER_CLK_I,
	input  wire logic                         SER_DATA_I,
	input  wire logic                         LOAD_STROBE_I,
	input  wire logic                         CHIP_EN_I,
	// Divider inputs.
	input  wire logic                         RF_IN_I,
	input  wire logic                         REF_IN_I,
	// Latch contents.
	output logic [sspl_pkg::SHIFT_W-1:0]      LATCH_REF_O,
	output logic [sspl_pkg::SHIFT_W-1:0]      LATCH_DIV_O,
	output logic [sspl_pkg::SHIFT_W-1:0]      LATCH_FUNC_O,
	// Power, pump, fast settle and monitor.
	output logic                              POWERED_O,
	output logic                              PUMP_UP_O,
	output logic                              PUMP_DN_O,
	output logic                              PUMP_OUTPUT_OE_N_O,
	output logic                              FAST_SETTLE_OUTPUT_O,
	output logic                              DIVIDER_LOCK_MONITOR_OUT_O
);

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection.

	localparam int P_SCLK = 5;
	localparam int P_DATA = 4;
	localparam int P_LOAD = 3;
	localparam int P_CEN  = 2;
	localparam int P_RF   = 1;
	localparam int P_REF  = 0;

	logic [sspl_pkg::PIN_N-1:0] meta_q;
	logic [sspl_pkg::PIN_N-1:0] sync_q;
	logic [sspl_pkg::PIN_N-1:0] last_q;

	wire  [sspl_pkg::PIN_N-1:0] pins = {SER_CLK_I, SER_DATA_I, LOAD_STROBE_I,
		CHIP_EN_I, RF_IN_I, REF_IN_I};
	wire  [sspl_pkg::PIN_N-1:0] rise = sync_q & ~last_q;

	wire                        sclk_rise = rise[P_SCLK];
	wire                        load_rise = rise[P_LOAD];
	wire                        data_s    = sync_q[P_DATA];
	wire                        chip_en_s = sync_q[P_CEN];

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			meta_q <= '0;
			sync_q <= '0;
			last_q <= '0;
		end else if (CE_I) begin
			meta_q <= pins;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shift register and latches.

	function automatic logic ctrl_is(input logic [sspl_pkg::SHIFT_W-1:0] word,
		input logic [1:0] code);
		ctrl_is = (word[sspl_pkg::CTRL_W-1:0] == code);
	endfunction

	logic [sspl_pkg::SHIFT_W-1:0] shift_q;
	logic [sspl_pkg::SHIFT_W-1:0] latch_q [sspl_pkg::N_LATCH];

	wire  [sspl_pkg::SHIFT_W-1:0] shift_d = {shift_q[sspl_pkg::SHIFT_W-2:0], data_s};

	// The newest bit lands in position 0, so the word's last two bits are the code.
	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			shift_q <= sspl_pkg::LATCH_RST;
		end else if (CE_I && sclk_rise) begin
			shift_q <= shift_d; // see R1
		end
	end

	// A word whose code is unused is dropped, leaving every latch intact.
	for (genvar i = 0; i < sspl_pkg::N_LATCH; i++) begin : g_latch
		wire hit = load_rise && ctrl_is(shift_q, 2'(i)); // see R3
		always_ff @(posedge CLK_SYS_I) begin
			if (RST_I) begin
				latch_q[i] <= sspl_pkg::LATCH_RST;
			end else if (CE_I && hit) begin
				latch_q[i] <= shift_q; // see R4, R10
			end
		end
	end

	assign LATCH_REF_O  = latch_q[sspl_pkg::LATCH_REF];
	assign LATCH_DIV_O  = latch_q[sspl_pkg::LATCH_DIV];
	assign LATCH_FUNC_O = latch_q[sspl_pkg::LATCH_FUNC];

	wire [sspl_pkg::SHIFT_W-1:0] func = latch_q[sspl_pkg::LATCH_FUNC];
	wire [sspl_pkg::SHIFT_W-1:0] ndiv = latch_q[sspl_pkg::LATCH_DIV];

	wire                         powerdown_request_bit = func[sspl_pkg::FUNC_PD_BIT];
	wire [sspl_pkg::FUNC_MON_W-1:0] mon_sel =
		func[sspl_pkg::FUNC_MON_LSB +: sspl_pkg::FUNC_MON_W];

	////////////////////////////////////////////////////////////////////////////////
	// Divider chain.

	sspl_if div_bus ();

	assign div_bus.run       = POWERED_O;
	assign div_bus.rf_tick   = rise[P_RF];
	assign div_bus.ref_tick  = rise[P_REF];
	assign div_bus.ref_count = latch_q[sspl_pkg::LATCH_REF][sspl_pkg::REF_LSB +: sspl_pkg::REF_W];
	assign div_bus.a_count   = ndiv[sspl_pkg::A_LSB +: sspl_pkg::A_W];
	assign div_bus.b_count   = ndiv[sspl_pkg::B_LSB +: sspl_pkg::B_W];

	sspl_div #(
		.PRESCALE (PRESCALE)
	) u_div (
		.clk_i (CLK_SYS_I),
		.rst_i (RST_I),
		.ce_i  (CE_I),
		.bus   (div_bus.div)
	);

	wire ref_pulse = div_bus.ref_pulse;
	wire rf_pulse  = div_bus.rf_pulse;

	////////////////////////////////////////////////////////////////////////////////
	// Power control, phase detector, lock and monitor.

	logic lock_q;

	wire powered_d = chip_en_s && !powerdown_request_bit; // see R5, R6
	wire pump_oe_n_d = !powered_d || func[sspl_pkg::FUNC_PUMP_OFF_BIT]; // see R5
	wire up_set = PUMP_UP_O || ref_pulse;
	wire dn_set = PUMP_DN_O || rf_pulse;
	// Both sides set means the edges met; the detector clears itself.
	wire pfd_clr = up_set && dn_set;
	wire pump_up_d = powered_d && up_set && !pfd_clr;
	wire pump_dn_d = powered_d && dn_set && !pfd_clr;
	wire fast_d = powered_d && func[sspl_pkg::FUNC_FAST_BIT];
	wire mon_d = (mon_sel == sspl_pkg::MON_LOCK) ? lock_q :
		(mon_sel == sspl_pkg::MON_NDIV) ? rf_pulse :
		(mon_sel == sspl_pkg::MON_RDIV) ? ref_pulse : 1'b0; // see R7

	always_ff @(posedge CLK_SYS_I) begin
		if (RST_I) begin
			POWERED_O                  <= 1'b0;
			PUMP_OUTPUT_OE_N_O         <= 1'b1;
			PUMP_UP_O                  <= 1'b0;
			PUMP_DN_O                  <= 1'b0;
			FAST_SETTLE_OUTPUT_O       <= 1'b0;
			DIVIDER_LOCK_MONITOR_OUT_O <= 1'b0;
			lock_q                     <= 1'b0;
		end else if (CE_I) begin
			POWERED_O                  <= powered_d;
			PUMP_OUTPUT_OE_N_O         <= pump_oe_n_d;
			PUMP_UP_O                  <= pump_up_d;
			PUMP_DN_O                  <= pump_dn_d;
			FAST_SETTLE_OUTPUT_O       <= fast_d;
			DIVIDER_LOCK_MONITOR_OUT_O <= mon_d;
			// Lock means the last divider event had both edges in one cycle.
			if (!powered_d) begin
				lock_q <= 1'b0;
			end else if (ref_pulse || rf_pulse) begin
				lock_q <= ref_pulse && rf_pulse;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	AST_SHIFT_IN: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see R1
		(CE_I && sclk_rise) |=> (shift_q == {$past(shift_q[19:0]), $past(data_s)}))
		else $error("Shift register did not take the sampled data bit.");

	AST_LOAD_REF: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see R3
		(CE_I && load_rise && shift_q[1:0] == sspl_pkg::CTRL_REF)
		|=> (LATCH_REF_O == $past(shift_q)))
		else $error("Reference word not loaded.");

	AST_LOAD_FUNC: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see R4
		(CE_I && load_rise && shift_q[1:0] == sspl_pkg::CTRL_FUNC)
		|=> (LATCH_FUNC_O == $past(shift_q)) && $stable(LATCH_DIV_O))
		else $error("Function word not loaded alone.");

	AST_LATCH_HOLD: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see R10
		!load_rise |=> $stable(LATCH_REF_O) && $stable(LATCH_DIV_O) && $stable(LATCH_FUNC_O))
		else $error("Latch changed without a load strobe.");

	AST_PUMP_OFF: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see R5
		(CE_I && !chip_en_s) |=> PUMP_OUTPUT_OE_N_O && !POWERED_O && !PUMP_UP_O)
		else $error("Pump driven while chip enable low.");

	AST_POWER_UP: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see R6
		(CE_I && chip_en_s) |=> (POWERED_O == !$past(powerdown_request_bit)))
		else $error("Power state disagrees with the power-down bit.");

	AST_MONITOR: assert property (@(posedge CLK_SYS_I) disable iff (RST_I) // see R7
		(CE_I && mon_sel == sspl_pkg::MON_NDIV) |=> (DIVIDER_LOCK_MONITOR_OUT_O == $past(rf_pulse)))
		else $error("Monitor does not follow the RF divider.");

	COV_LOAD_DIV: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
		load_rise && shift_q[1:0] == sspl_pkg::CTRL_DIV);
	COV_POWER_UP: cover property (@(posedge CLK_SYS_I) disable iff (RST_I)
		!POWERED_O ##1 POWERED_O);
	COV_LOCK: cover property (@(posedge CLK_SYS_I) disable iff (RST_I) lock_q);

endmodule // sspl_top

`default_nettype wire

// ==== sspl_host_model.sv ====
/*
 * Host controller model that drives the three-wire programming pins.
 * Assumes the system clock of the bench; pins change only at its falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module sspl_host_model (
	// Timing reference.
	input  wire logic clk_i,
	// Programming pins.
	output logic      ser_clk_o,
	output logic      ser_data_o,
	output logic      load_strobe_o
);
	initial begin
		ser_clk_o     = 1'b0;
		ser_data_o    = 1'b0;
		load_strobe_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// The serial clock idles low between words; 40 ns high and low gives 80 ns.
	task automatic send_word(input logic [20:0] w, input bit strobe);
		for (int i = 20; i >= 0; i--) begin
			ser_data_o = w[i];
			repeat (4) @(negedge clk_i);
			ser_clk_o = 1'b1;
			repeat (4) @(negedge clk_i);
			ser_clk_o = 1'b0;
		end
		// The line is not left showing the last bit once its hold time is over.
		ser_data_o = ~w[0];
		if (strobe) begin
			repeat (4) @(negedge clk_i);
			load_strobe_o = 1'b1;
			repeat (8) @(negedge clk_i);
			load_strobe_o = 1'b0;
		end
		repeat (4) @(negedge clk_i);
	endtask
endmodule // sspl_host_model

`default_nettype wire

// ==== synth_serial_program_load_test.sv ====
/*
 * Self-checking bench of the serial program load block.
 * Assumes the design package and the host model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module synth_serial_program_load_test;
	logic        clk_sys = 1'b0;
	logic        rst     = 1'b1;
	logic        chip_en = 1'b0;
	logic        rf_in   = 1'b0;
	logic        ref_in  = 1'b0;
	logic        ser_clk;
	logic        ser_data;
	logic        load_strobe;
	logic [20:0] lat [3];
	logic        powered;
	logic        pump_up;
	logic        pump_dn;
	logic        oe_n;
	logic        fast;
	logic        mon;
	int          n_errors    = 0;
	int          checks_done = 0;
	int          cycles      = 0;

	always #5 clk_sys = ~clk_sys;

	sspl_host_model u_host (
		.clk_i         (clk_sys),
		.ser_clk_o     (ser_clk),
		.ser_data_o    (ser_data),
		.load_strobe_o (load_strobe)
	);

	// A small prescaler keeps divider runs short.
	sspl_top #(.PRESCALE(8)) u_dut (
		.CLK_SYS_I                  (clk_sys),
		.RST_I                      (rst),
		.CE_I                       (1'b1),
		.SER_CLK_I                  (ser_clk),
		.SER_DATA_I                 (ser_data),
		.LOAD_STROBE_I              (load_strobe),
		.CHIP_EN_I                  (chip_en),
		.RF_IN_I                    (rf_in),
		.REF_IN_I                   (ref_in),
		.LATCH_REF_O                (lat[0]),
		.LATCH_DIV_O                (lat[1]),
		.LATCH_FUNC_O               (lat[2]),
		.POWERED_O                  (powered),
		.PUMP_UP_O                  (pump_up),
		.PUMP_DN_O                  (pump_dn),
		.PUMP_OUTPUT_OE_N_O         (oe_n),
		.FAST_SETTLE_OUTPUT_O       (fast),
		.DIVIDER_LOCK_MONITOR_OUT_O (mon)
	);

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [20:0] seen, input logic [20:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	function automatic logic [20:0] func_word(input logic pd, input logic [2:0] sel);
		return (21'(pd) << sspl_pkg::FUNC_PD_BIT) | (21'(sel) << sspl_pkg::FUNC_MON_LSB)
			| 21'(sspl_pkg::CTRL_FUNC);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		for (int i = 0; i < 3; i++)
			check(lat[i], 21'h000000, "latch after reset");
		check(21'(powered), 21'h0, "powered after reset");
		check(21'(oe_n), 21'h1, "pump enable after reset");
		$display("test reset done");
	endtask

	// Every control code, the unused one included, then a word with no strobe.
	task automatic t_load;
		logic [20:0] words [4];
		logic [20:0] exp [3];
		words = '{21'h15a5a4, 21'h000185, func_word(1'b0, sspl_pkg::MON_LOW), 21'h1fffff};
		exp   = '{21'h000000, 21'h000000, 21'h000000};
		foreach (words[k]) begin
			u_host.send_word(words[k], 1'b1);
			if (words[k][1:0] != 2'h3)
				exp[words[k][1:0]] = words[k];
			for (int i = 0; i < 3; i++)
				check(lat[i], exp[i], "latch after load");
		end
		u_host.send_word(21'h0aaaa9, 1'b0);
		for (int i = 0; i < 3; i++)
			check(lat[i], exp[i], "latch after shift only");
		$display("test load done");
	endtask

	task automatic t_power;
		logic [20:0] fw;
		chip_en = 1'b1;
		wait_cyc(6);
		check(21'(powered), 21'h1, "power up");
		check(21'(oe_n), 21'h0, "pump driven");
		u_host.send_word(func_word(1'b1, sspl_pkg::MON_LOW), 1'b1);
		wait_cyc(6);
		check(21'(powered), 21'h0, "power-down bit");
		check(21'(oe_n), 21'h1, "pump released by bit");
		u_host.send_word(func_word(1'b0, sspl_pkg::MON_LOW), 1'b1);
		wait_cyc(6);
		check(21'(powered), 21'h1, "power up again");
		fw = func_word(1'b0, sspl_pkg::MON_LOW) | (21'h000001 << sspl_pkg::FUNC_FAST_BIT);
		u_host.send_word(fw, 1'b1);
		wait_cyc(6);
		check(21'(fast), 21'h1, "fast settle on");
		check(21'(oe_n), 21'h0, "pump still driven");
		u_host.send_word(fw | (21'h000001 << sspl_pkg::FUNC_PUMP_OFF_BIT), 1'b1);
		wait_cyc(6);
		check(21'(oe_n), 21'h1, "pump off bit");
		check(21'(powered), 21'h1, "powered with pump off");
		chip_en = 1'b0;
		wait_cyc(6);
		check(21'(powered), 21'h0, "enable low");
		check(21'(oe_n), 21'h1, "pump high impedance");
		check(21'(pump_up | pump_dn), 21'h0, "pump idle");
		check(21'(fast), 21'h0, "fast settle off");
		$display("test power done");
	endtask

	// Counts monitor pulses while the chosen inputs toggle with an 80 ns period.
	task automatic count_mon(input bit do_rf, input bit do_ref, input int edges, output int cnt);
		logic prev;
		cnt  = 0;
		prev = mon;
		for (int e = 0; e < 2 * edges * 4; e++) begin
			if (e % 4 == 0) begin
				if (do_rf)
					rf_in = ~rf_in;
				if (do_ref)
					ref_in = ~ref_in;
			end
			@(negedge clk_sys);
			if (mon && !prev)
				cnt++;
			prev = mon;
		end
	endtask

	task automatic t_monitor;
		int cnt;
		int n_div;
		n_div = 8 * 3 + 1;
		chip_en = 1'b1;
		u_host.send_word(21'h000014, 1'b1);
		u_host.send_word(func_word(1'b0, sspl_pkg::MON_LOW), 1'b1);
		count_mon(1'b1, 1'b0, 100, cnt);
		check(21'(cnt), 21'h0, "monitor low");
		u_host.send_word(func_word(1'b0, sspl_pkg::MON_NDIV), 1'b1);
		count_mon(1'b1, 1'b0, 100, cnt);
		check(21'(cnt >= 100 / n_div - 1 && cnt <= 100 / n_div), 21'h1, "rf divider");
		u_host.send_word(func_word(1'b0, sspl_pkg::MON_RDIV), 1'b1);
		count_mon(1'b0, 1'b1, 50, cnt);
		check(21'(cnt >= 9 && cnt <= 10), 21'h1, "ref divider");
		$display("test monitor done");
	endtask

	// Both inputs share edges from a fresh power-up. The RF divider fires at tick 8, then
	// every 35 (B = 4, A = 3); the reference one at tick 1, then every 7, so both meet at
	// ticks 8, 43 and 78 and the lock flag rises three times in 80 ticks.
	task automatic t_lock;
		int cnt;
		u_host.send_word(21'h00001c, 1'b1);
		u_host.send_word(21'h00020d, 1'b1);
		u_host.send_word(func_word(1'b0, sspl_pkg::MON_LOCK), 1'b1);
		chip_en = 1'b0;
		wait_cyc(6);
		chip_en = 1'b1;
		wait_cyc(6);
		count_mon(1'b1, 1'b1, 80, cnt);
		check(21'(cnt), 21'h3, "lock detect");
		$display("test lock done");
	endtask

	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	initial begin
		wait_cyc(6);
		rst = 1'b0;
		wait_cyc(2);
		t_reset();
		t_load();
		t_power();
		t_monitor();
		t_lock();
		wrap_up();
	end
endmodule // synth_serial_program_load_test

`default_nettype wire
